// *** inc/chrri_consts.svh ***
`ifndef CHRRI_CONSTS_SVH
`define CHRRI_CONSTS_SVH
// Clock period of mclk
`define CHRRI_CLK_NS 10
// Internal power-up and reset processing time
`define CHRRI_INIT_NS 1000
`define CHRRI_INIT_CYC ((`CHRRI_INIT_NS + `CHRRI_CLK_NS - 1) / `CHRRI_CLK_NS)
// Width of a pulse-mode interrupt
`define CHRRI_IRQ_PULSE_NS 100
`define CHRRI_IRQ_CYC \
   ((`CHRRI_IRQ_PULSE_NS + `CHRRI_CLK_NS - 1) / `CHRRI_CLK_NS)
// Counter width for both timers
`define CHRRI_CNT_W 8
// Stages in each synchroniser
`define CHRRI_SYNC_STAGES 2
// Card synchroniser reset: reset pin reads high, so it arms only once low
`define CHRRI_CARD_SYNC_RST 4'hf
// Host synchroniser reset: card busy, no interrupt, no DMA request
`define CHRRI_HOST_SYNC_RST 4'h4
`endif

// *** inc/chrri_pkg.sv ***
package chrri_pkg;
   typedef enum logic [1:0] {
      CHRRI_MEM,
      CHRRI_IO,
      CHRRI_IDE
   } chrri_mode_e;
   typedef enum logic [1:0] {
      CHRRI_HELD,
      CHRRI_INIT,
      CHRRI_RUN
   } chrri_state_e;
   typedef logic [7:0] chrri_cnt_t;
endpackage : chrri_pkg

// *** inc/chrri_if.sv ***
`timescale 1ns/100ps
interface chrri_if;
   logic card_reset;
   logic ide_mode_select_n;
   logic attr_space_n;
   logic dma_acknowledge_n;
   logic ready;
   logic io_interrupt_request_n;
   logic ide_interrupt_line;
   logic dma_request_line;
   modport card (
      input card_reset,
      input ide_mode_select_n,
      input attr_space_n,
      input dma_acknowledge_n,
      output ready,
      output io_interrupt_request_n,
      output ide_interrupt_line,
      output dma_request_line
   );
   modport host (
      output card_reset,
      output ide_mode_select_n,
      output attr_space_n,
      output dma_acknowledge_n,
      input ready,
      input io_interrupt_request_n,
      input ide_interrupt_line,
      input dma_request_line
   );
endinterface : chrri_if

// *** core/chrri_sync.sv ***
`timescale 1ns/100ps
module chrri_sync #(
   parameter int W = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] rst_val,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // Two flops; only the second stage reads the first
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta <= rst_val;
         q <= rst_val;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : chrri_sync

// *** core/chrri_card.sv ***
// Overview of operation
// R1: Ready high when idle, low when busy
// R2: Ready low until reset processing ends
// R3: Host makes no access while busy
// R4: Reset held from power-up disables pin reset
// R5: I/O interrupt low pulse or low level
// R6: IDE interrupt line is active high
// R7: Attribute select high common, low attribute
// R8: Host drives attribute select low for I/O
// R9: Host acknowledges DMA request with low level
// R10: Acknowledge ignored while no DMA active
// R11: Non-DMA IDE host holds acknowledge high
// R12: Reset high holds card in reset
// R13: Initial reset always completes at power-up
// R14: Soft reset bit also resets card
// R15: IDE mode reset input is active low
// R16: Host grounds mode select for IDE
// R17: Non-DMA dual host may keep wiring
// R18: Synchronise pin inputs before use
`timescale 1ns/100ps
`include "chrri_consts.svh"
module chrri_card (
   input wire logic mclk,
   input wire logic rst,
   chrri_if.card bus,
   input wire logic core_busy,
   input wire logic io_configured,
   input wire logic irq_pending,
   input wire logic irq_pulse_mode,
   input wire logic soft_reset_bit,
   input wire logic dma_req,
   input wire logic dma_active,
   output logic core_reset,
   output chrri_pkg::chrri_mode_e link_mode,
   output logic attr_space,
   output logic dma_ack
);
   import chrri_pkg::*;

   logic [3:0] pins_s;
   logic rst_pin_s;
   logic mode_sel_n_s;
   logic attr_n_s;
   logic dma_acknowledge_n_n_s;
   logic pin_armed;
   logic pin_reset;
   logic reset_req;
   logic init_done;
   logic irq_prev;
   logic irq_rise;
   logic run;
   logic is_ide;
   logic is_io;
   logic is_mem;
   chrri_state_e state;
   chrri_state_e next_state;
   chrri_mode_e next_mode;
   chrri_cnt_t init_cnt;
   chrri_cnt_t irq_cnt;

   // Pin inputs cross into mclk before any logic reads them
   chrri_sync #(
      .W(4)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d({bus.card_reset, bus.ide_mode_select_n, bus.attr_space_n,
          bus.dma_acknowledge_n}),
      .rst_val(`CHRRI_CARD_SYNC_RST),
      .q(pins_s)
   ); // R18

   assign rst_pin_s = pins_s[3];
   assign mode_sel_n_s = pins_s[2];
   assign attr_n_s = pins_s[1];
   assign dma_acknowledge_n_n_s = pins_s[0];

   assign is_ide = (link_mode == CHRRI_IDE);
   assign is_io = (link_mode == CHRRI_IO);
   assign is_mem = (link_mode == CHRRI_MEM);
   assign run = (state == CHRRI_RUN);

   // Interface mode from the grounded select pin and I/O configuration
   always_comb begin
      if (!mode_sel_n_s) begin
         next_mode = CHRRI_IDE;
      end else if (io_configured) begin
         next_mode = CHRRI_IO;
      end else begin
         next_mode = CHRRI_MEM;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         link_mode <= CHRRI_MEM;
      end else begin
         link_mode <= next_mode;
      end
   end

   // Memory and I/O mode pin reset stays disabled until the pin has once been seen released
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_armed <= 1'b0;
      end else if (!rst_pin_s) begin
         pin_armed <= 1'b1; // R4
      end
   end

   // Active high in memory and I/O modes, active low in IDE mode
   always_comb begin
      if (!mode_sel_n_s) begin
         pin_reset = !rst_pin_s; // R15
      end else begin
         pin_reset = rst_pin_s && pin_armed; // R12
      end
   end

   assign reset_req = pin_reset || soft_reset_bit; // R14
   assign init_done = (init_cnt == chrri_cnt_t'(`CHRRI_INIT_CYC - 1));

   // Reset sequencing: held, then processing, then running
   always_comb begin
      next_state = state;
      unique case (state)
         CHRRI_HELD: begin
            if (!reset_req) begin
               next_state = CHRRI_INIT;
            end
         end
         CHRRI_INIT: begin
            if (reset_req) begin
               next_state = CHRRI_HELD;
            end else if (init_done) begin
               next_state = CHRRI_RUN;
            end
         end
         CHRRI_RUN: begin
            if (reset_req) begin
               next_state = CHRRI_HELD;
            end
         end
         default: begin
            next_state = CHRRI_HELD;
         end
      endcase
   end

   // Power-up always starts with one full reset processing
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= CHRRI_INIT; // R13
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         init_cnt <= '0;
      end else if (state != CHRRI_INIT || next_state != CHRRI_INIT) begin
         init_cnt <= '0;
      end else begin
         init_cnt <= init_cnt + chrri_cnt_t'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         core_reset <= 1'b1;
      end else begin
         core_reset <= (next_state != CHRRI_RUN);
      end
   end

   // Busy while reset or processing runs, or while the core is busy
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.ready <= 1'b0; // R2
      end else begin
         bus.ready <= (next_state == CHRRI_RUN) && !core_busy; // R1 R2
      end
   end

   // Pulse-mode interrupt starts on a new pending request
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_prev <= 1'b0;
      end else begin
         irq_prev <= irq_pending;
      end
   end

   assign irq_rise = irq_pending && !irq_prev;

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_cnt <= '0;
      end else if (!run || !is_io || !irq_pulse_mode) begin
         irq_cnt <= '0;
      end else if (irq_rise) begin
         irq_cnt <= chrri_cnt_t'(`CHRRI_IRQ_CYC);
      end else if (irq_cnt != '0) begin
         irq_cnt <= irq_cnt - chrri_cnt_t'(1);
      end
   end

   // I/O interrupt: strobed low or held low, only once configured
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.io_interrupt_request_n <= 1'b1;
      end else if (!run || !is_io) begin
         bus.io_interrupt_request_n <= 1'b1;
      end else if (irq_pulse_mode) begin
         bus.io_interrupt_request_n <=
            !(irq_rise || irq_cnt > chrri_cnt_t'(1)); // R5
      end else begin
         bus.io_interrupt_request_n <= !irq_pending; // R5
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.ide_interrupt_line <= 1'b0;
      end else begin
         bus.ide_interrupt_line <= run && is_ide && irq_pending; // R6
      end
   end

   // Memory cycles: low selects attribute space, high common space
   always_ff @(posedge mclk) begin
      if (rst) begin
         attr_space <= 1'b0;
      end else begin
         attr_space <= run && is_mem && !attr_n_s; // R7
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.dma_request_line <= 1'b0;
      end else begin
         bus.dma_request_line <= run && is_ide && dma_req;
      end
   end

   // Acknowledge counts only while a DMA operation is active
   always_ff @(posedge mclk) begin
      if (rst) begin
         dma_ack <= 1'b0;
      end else begin
         dma_ack <= run && is_ide && dma_active && !dma_acknowledge_n_n_s; // R10
      end
   end
endmodule : chrri_card

// *** core/chrri_host.sv ***
`timescale 1ns/100ps
`include "chrri_consts.svh"
module chrri_host (
   input wire logic mclk,
   input wire logic rst,
   chrri_if.host bus,
   input wire logic host_reset,
   input wire logic use_ide,
   input wire logic dma_capable,
   input wire logic dma_go,
   input wire logic access_req,
   input wire logic access_attr,
   input wire logic access_io,
   output logic card_ready,
   output logic card_irq,
   output logic card_dma_req,
   output logic access_grant,
   output logic access_refused
);
   import chrri_pkg::*;

   logic [3:0] pins_s;

   // Card outputs cross into mclk
   chrri_sync #(
      .W(4)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d({bus.ready, bus.io_interrupt_request_n, bus.ide_interrupt_line,
          bus.dma_request_line}),
      .rst_val(`CHRRI_HOST_SYNC_RST),
      .q(pins_s)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         card_ready <= 1'b0;
         card_irq <= 1'b0;
         card_dma_req <= 1'b0;
      end else begin
         card_ready <= pins_s[3];
         card_irq <= use_ide ? pins_s[1] : !pins_s[2];
         card_dma_req <= pins_s[0];
      end
   end

   // Reset pin polarity follows the selected mode
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.card_reset <= 1'b0;
      end else begin
         bus.card_reset <= use_ide ? !host_reset : host_reset;
      end
   end

   // Same wiring serves both modes; the select pin and the reset pin polarity change
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.ide_mode_select_n <= 1'b1;
      end else begin
         bus.ide_mode_select_n <= !use_ide; // R16 R17
      end
   end

   // Attribute select: low for attribute and for every I/O cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.attr_space_n <= 1'b1;
      end else if (access_io) begin
         bus.attr_space_n <= 1'b0; // R8
      end else begin
         bus.attr_space_n <= !access_attr; // R7
      end
   end

   // Acknowledge only answers a request; held high without DMA
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus.dma_acknowledge_n <= 1'b1; // R11
      end else begin
         bus.dma_acknowledge_n <= !(use_ide && dma_capable && dma_go &&
                                    pins_s[0]); // R9 R11
      end
   end

   // No access of any kind while the card reports busy
   always_ff @(posedge mclk) begin
      if (rst) begin
         access_grant <= 1'b0;
         access_refused <= 1'b0;
      end else begin
         access_grant <= access_req && pins_s[3] && !host_reset; // R3
         access_refused <= access_req && !(pins_s[3] && !host_reset); // R3
      end
   end
endmodule : chrri_host

// *** sim/chrri_props.sv ***
`timescale 1ns/100ps
module chrri_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic card_reset,
   input wire logic ide_mode_select_n,
   input wire logic attr_space_n,
   input wire logic dma_acknowledge_n,
   input wire logic ready,
   input wire logic io_interrupt_request_n,
   input wire logic ide_interrupt_line,
   input wire logic dma_request_line
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   AST_IO_IRQ_IDLE: assert property (
      (!ide_mode_select_n)[*4] |-> io_interrupt_request_n)
      else $error("io irq in ide mode");
   AST_IDE_IRQ_IDLE: assert property (
      ide_mode_select_n[*4] |-> !ide_interrupt_line)
      else $error("ide irq outside ide mode");
   AST_DREQ_IDLE: assert property (
      ide_mode_select_n[*4] |-> !dma_request_line)
      else $error("dma request outside ide mode");
   AST_MEM_RESET_BUSY: assert property (
      $rose(card_reset) && $past(ide_mode_select_n, 3) ##1
      (card_reset && ide_mode_select_n)[*5] |-> !ready)
      else $error("ready high while reset held");
   AST_IDE_RESET_BUSY: assert property (
      (!ide_mode_select_n && !card_reset)[*6] |-> !ready)
      else $error("ready high during ide reset");
   AST_IDE_INIT_BUSY: assert property (
      $rose(card_reset) && !$past(ide_mode_select_n, 3)
      |-> ##5 (!ready)[*8])
      else $error("ready high during reset processing");
   AST_DMA_ACKNOWLEDGE_N_AFTER_REQ: assert property (
      $fell(dma_acknowledge_n) |-> $past(dma_request_line, 3))
      else $error("dma acknowledge without request");
   AST_IDE_READY_RELEASED: assert property (
      $rose(ready) && !ide_mode_select_n |-> $past(card_reset, 6))
      else $error("ready rose soon after ide reset");
endmodule : chrri_props

// *** sim/tb.sv ***
`timescale 1ns/100ps
`include "chrri_consts.svh"
module tb;
   import chrri_pkg::*;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic crst = 1'h0;
   logic rst_c;
   logic busy = 1'h0, io_cfg = 1'h0, irq = 1'h0, pulse = 1'h0;
   logic srst = 1'h0, dreq = 1'h0, dact = 1'h0, hrst = 1'h0;
   logic ide = 1'h0, dcap = 1'h0, dgo = 1'h0, areq = 1'h0;
   logic aattr = 1'h0, aio = 1'h0;
   logic core_reset, attr_space, dma_ack, c_rdy, c_irq, c_dreq;
   logic grant, refused;
   chrri_mode_e link_mode;
   int failures = 0;
   int num_checks = 0;
   int mode_m = 0;
   int i, n;
   logic q[$];
   assign rst_c = rst | crst;
   always #5 mclk = ~mclk;
   chrri_if bus ();
   chrri_card u_chrri_card (.mclk(mclk), .rst(rst_c), .bus(bus.card),
      .core_busy(busy), .io_configured(io_cfg), .irq_pending(irq),
      .irq_pulse_mode(pulse), .soft_reset_bit(srst), .dma_req(dreq),
      .dma_active(dact), .core_reset(core_reset), .link_mode(link_mode),
      .attr_space(attr_space), .dma_ack(dma_ack));
   chrri_host u_chrri_host (.mclk(mclk), .rst(rst), .bus(bus.host),
      .host_reset(hrst), .use_ide(ide), .dma_capable(dcap),
      .dma_go(dgo), .access_req(areq), .access_attr(aattr),
      .access_io(aio), .card_ready(c_rdy), .card_irq(c_irq),
      .card_dma_req(c_dreq), .access_grant(grant),
      .access_refused(refused));
   chrri_props u_chrri_props (.mclk(mclk), .rst(rst_c),
      .card_reset(bus.card_reset),
      .ide_mode_select_n(bus.ide_mode_select_n),
      .attr_space_n(bus.attr_space_n),
      .dma_acknowledge_n(bus.dma_acknowledge_n), .ready(bus.ready),
      .io_interrupt_request_n(bus.io_interrupt_request_n),
      .ide_interrupt_line(bus.ide_interrupt_line),
      .dma_request_line(bus.dma_request_line));
   task chk(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t value mismatch", $time);
      end
   endtask : chk
   task chkm(input chrri_mode_e g, input chrri_mode_e e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t mode mismatch", $time);
      end
   endtask : chkm
   task cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask : cyc
   task wrdy(input logic v);
      int j;
      for (j = 0; j < 300 && bus.ready !== v; j++) cyc(1);
      chk(bus.ready, v);
   endtask : wrdy
   task acc(input logic a, input logic io);
      logic e;
      q.push_back(mode_m == 0 && !io && a);
      areq = 1'h1;
      aattr = a;
      aio = io;
      cyc(1);
      areq = 1'h0;
      chk(grant, 1'h1);
      chk(bus.attr_space_n, !(io | a));
      cyc(4);
      e = q.pop_front();
      chk(attr_space, e);
   endtask : acc
   task results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      #200000;
      failures++;
      results();
   end
   initial begin
      void'($urandom(32'h0000_81dc));
      cyc(5);
      rst = 1'h0;
      cyc(40);
      chk(bus.ready, 1'h0);
      wrdy(1'h1);
      cyc(4);
      chkm(link_mode, CHRRI_MEM);
      chk(c_rdy, 1'h1);
      $display("power-up done");
      busy = 1'h1;
      cyc(3);
      chk(bus.ready, 1'h0);
      cyc(3);
      areq = 1'h1;
      cyc(1);
      areq = 1'h0;
      chk(refused, 1'h1);
      busy = 1'h0;
      cyc(3);
      chk(bus.ready, 1'h1);
      cyc(4);
      for (i = 0; i < 6; i++) acc(1'($urandom), 1'h0);
      $display("memory access done");
      srst = 1'h1;
      cyc(1);
      srst = 1'h0;
      cyc(1);
      chk(bus.ready, 1'h0);
      chk(core_reset, 1'h1);
      wrdy(1'h1);
      $display("soft reset done");
      hrst = 1'h1;
      cyc(10);
      chk(bus.ready, 1'h0);
      crst = 1'h1;
      cyc(5);
      crst = 1'h0;
      wrdy(1'h1);
      hrst = 1'h0;
      cyc(5);
      hrst = 1'h1;
      cyc(8);
      chk(bus.ready, 1'h0);
      chk(core_reset, 1'h1);
      hrst = 1'h0;
      wrdy(1'h1);
      cyc(4);
      $display("pin reset done");
      io_cfg = 1'h1;
      mode_m = 1;
      cyc(4);
      chkm(link_mode, CHRRI_IO);
      acc(1'($urandom), 1'h1);
      irq = 1'h1;
      cyc(2);
      chk(bus.io_interrupt_request_n, 1'h0);
      chk(bus.ide_interrupt_line, 1'h0);
      cyc(3);
      chk(c_irq, 1'h1);
      irq = 1'h0;
      cyc(2);
      chk(bus.io_interrupt_request_n, 1'h1);
      pulse = 1'h1;
      irq = 1'h1;
      n = 0;
      for (i = 0; i < 20; i++) begin
         cyc(1);
         if (bus.io_interrupt_request_n === 1'h0) n++;
      end
      chk(1'(n == `CHRRI_IRQ_CYC), 1'h1);
      irq = 1'h0;
      $display("io mode done");
      io_cfg = 1'h0;
      ide = 1'h1;
      mode_m = 2;
      cyc(10);
      chkm(link_mode, CHRRI_IDE);
      chk(bus.ide_mode_select_n, 1'h0);
      wrdy(1'h1);
      irq = 1'h1;
      cyc(2);
      chk(bus.ide_interrupt_line, 1'h1);
      chk(bus.io_interrupt_request_n, 1'h1);
      irq = 1'h0;
      dreq = 1'h1;
      dgo = 1'h1;
      cyc(8);
      chk(bus.dma_request_line, 1'h1);
      chk(bus.dma_acknowledge_n, 1'h1);
      dcap = 1'h1;
      cyc(8);
      chk(c_dreq, 1'h1);
      chk(bus.dma_acknowledge_n, 1'h0);
      chk(dma_ack, 1'h0);
      dact = 1'h1;
      cyc(5);
      chk(dma_ack, 1'h1);
      dreq = 1'h0;
      dact = 1'h0;
      dgo = 1'h0;
      hrst = 1'h1;
      cyc(8);
      chk(bus.card_reset, 1'h0);
      chk(bus.ready, 1'h0);
      hrst = 1'h0;
      wrdy(1'h1);
      $display("ide mode done");
      results();
   end
endmodule : tb
